//--- hw/flash_seq_consts.svh
// Purpose: constants of the flash command sequencer
// Assumes: 16-bit register port, ref_clk at 10 MHz
// Notes: offsets are word indices on the 2-bit register address
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// register word offsets
`define OFS_STATUS 2'h0
`define OFS_INDEX 2'h1
`define OFS_PARAM 2'h2
`define OFS_CONFIG 2'h3

// status bit positions
`define BIT_DONE 7
`define BIT_ACC 5
`define BIT_PROT 4
`define BIT_VERR 1
`define BIT_VUNC 0

// command codes
`define CMD_EV_SECT 8'h03
`define CMD_OTP_READ 8'h04
`define CMD_PROG 8'h06
`define CMD_OTP_PROG 8'h07

// parameter indices and limits
`define IDX_BLOCK 3'h0
`define IDX_ADDR 3'h1
`define IDX_COUNT 3'h2
`define IDX_LAST 3'h5
`define OTP_LAST 16'h0007
`define CODE_BLK_LO 7'h7C
`define OTP_BLK 7'h7C
`define BOUNDARY_BIT 18
`define ERASED_PHRASE 64'hFFFF_FFFF_FFFF_FFFF

// config register layout and reset
`define CONFIG_RESET 16'h000F
`define CFG_PEN 15
`define CFG_PBLK_LO 8

// program pulse timing
`define PROG_TIME_NS 20000
`define CLK_PERIOD_NS 100
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/flash_seq_pkg.sv
// Purpose: types of the flash command sequencer
// Assumes: constants live in flash_seq_consts.svh
// Notes: phrase index is global address bits [22:3]
package flash_seq_pkg;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_SCAN, ST_OTP_FETCH, ST_OTP_BLANK, ST_PROG_WAIT, ST_VERIFY
   } seq_state_t;

   // ==========================================================
   // status flags
   typedef struct packed {
      logic done;
      logic acc_err;
      logic prot_viol;
      logic ver_err;
      logic ver_unc;
   } status_t;

   // ==========================================================
   // phrase store access
   typedef struct packed {
      logic wr;
      logic otp;
      logic [19:0] idx;
      logic [63:0] wdata;
   } store_req_t;

   typedef struct packed {
      logic otp;
      logic [19:0] idx;
   } store_addr_t;

   // ==========================================================
   // whole sequencer state
   typedef struct packed {
      seq_state_t state;
      status_t status;
      logic [2:0] pidx;
      logic [5:0][15:0] params;
      logic [15:0] cfg;
      logic [7:0] cmd;
      logic [19:0] ph;
      logic [15:0] cnt;
      logic [7:0] timer;
      logic [15:0] rdata;
      logic [15:0] cpu_rdata;
      logic cpu_inv;
   } seq_regs_t;

endpackage

//--- hw/flash_phrase_store.sv
// Purpose: phrase array of code flash and one-time field
// Assumes: one write port, two asynchronous read ports
// Notes: srst returns every phrase to the erased state
`timescale 1ns/100ps
`include "flash_seq_consts.svh"
module flash_phrase_store #(
   parameter int PHRASES = 64,
   parameter int OTP_PHRASES = 8
) (
   input logic ref_clk,
   input logic srst,
   input flash_seq_pkg::store_req_t req,
   input flash_seq_pkg::store_addr_t addr_a,
   output logic [63:0] data_a,
   input flash_seq_pkg::store_addr_t addr_b,
   output logic [63:0] data_b
);
   localparam int AW = $clog2(PHRASES);
   localparam int OW = $clog2(OTP_PHRASES);

   logic [63:0] main_mem [PHRASES];
   logic [63:0] otp_mem [OTP_PHRASES];

   // ==========================================================
   // read one phrase, upper phrase bits alias onto the array
   function automatic logic [63:0] fetch(flash_seq_pkg::store_addr_t a);
      if (a.otp) begin
         return otp_mem[a.idx[OW-1:0]];
      end
      return main_mem[a.idx[AW-1:0]];
   endfunction

   assign data_a = fetch(addr_a);
   assign data_b = fetch(addr_b);

   // ==========================================================
   // erase on reset, program on write request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < PHRASES; i++) begin
            main_mem[i] <= `ERASED_PHRASE;
         end
         for (int i = 0; i < OTP_PHRASES; i++) begin
            otp_mem[i] <= `ERASED_PHRASE;
         end
      end else if (req.wr && req.otp) begin
         otp_mem[req.idx[OW-1:0]] <= req.wdata;
      end else if (req.wr) begin
         main_mem[req.idx[AW-1:0]] <= req.wdata;
      end
   end
endmodule // flash_phrase_store

//--- hw/flash_code_cmd_sequencer.sv
// Purpose: command sequencer for code flash and one-time field
// Assumes: register port with read data one cycle after read strobe
// Notes: one command at a time; register writes during a command are limited
`timescale 1ns/100ps
`include "flash_seq_consts.svh"
module flash_code_cmd_sequencer #(
   parameter int PHRASES = 64
) (
   input logic ref_clk,
   input logic srst,
   input logic [1:0] reg_addr,
   input logic [15:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [15:0] reg_rdata,
   input logic cpu_rd,
   input logic [22:0] cpu_addr,
   output logic [15:0] cpu_rdata,
   output logic cpu_data_invalid
);
   localparam flash_seq_pkg::seq_regs_t SEQ_RESET = '{
      state: flash_seq_pkg::ST_IDLE,
      status: '{done: 1'b1, default: 1'b0},
      cfg: `CONFIG_RESET,
      default: '0
   };
   localparam int PROG_N = `PROG_CYCLES;

   flash_seq_pkg::seq_regs_t s;
   flash_seq_pkg::seq_regs_t next_s;
   flash_seq_pkg::store_req_t req;
   flash_seq_pkg::store_addr_t addr_a;
   flash_seq_pkg::store_addr_t addr_b;
   logic [63:0] ph_a;
   logic [63:0] ph_b;
   logic [7:0] code;
   logic [6:0] blk;
   logic [22:0] gaddr;
   logic [23:0] last_addr;
   logic launch_try;
   logic addr_cmd;
   logic otp_cmd;
   logic bad_code;
   logic bad_avail;
   logic bad_idx;
   logic bad_align;
   logic bad_addr;
   logic bad_cross;
   logic bad_otp;
   logic acc_any;
   logic prot_hit;
   logic busy_otp;

   // ==========================================================
   // helper functions

   // command code to its availability bit in config
   function automatic logic [1:0] cmd_slot(logic [7:0] c);
      unique case (c)
         `CMD_EV_SECT: return 2'h0;
         `CMD_OTP_READ: return 2'h1;
         `CMD_PROG: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction

   // parameter index expected at launch
   function automatic logic [2:0] last_idx(logic [7:0] c);
      unique case (c)
         `CMD_EV_SECT: return `IDX_COUNT;
         `CMD_OTP_READ: return `IDX_ADDR;
         default: return `IDX_LAST;
      endcase
   endfunction

   // four data words as one phrase, word 0 highest
   function automatic logic [63:0] pack_words(logic [5:0][15:0] p);
      return {p[2], p[3], p[4], p[5]};
   endfunction

   // word w of a phrase
   function automatic logic [15:0] word_of(logic [63:0] ph, logic [1:0] w);
      return ph[(3 - w) * 16 +: 16];
   endfunction

   // compare read data: {any error, more than one bit wrong}
   function automatic logic [1:0] check(logic [63:0] got, logic [63:0] want);
      logic [63:0] diff;
      logic [6:0] ones;
      diff = got ^ want;
      ones = 7'h00;
      for (int i = 0; i < 64; i++) begin
         ones = ones + {6'h00, diff[i]};
      end
      return {|diff, ones > 7'h01};
   endfunction

   // ==========================================================
   // launch decode from the parameter registers
   assign code = s.params[`IDX_BLOCK][15:8];
   assign blk = s.params[`IDX_BLOCK][6:0];
   assign gaddr = {blk, s.params[`IDX_ADDR]};
   assign last_addr = {1'b0, gaddr} + 24'({s.params[`IDX_COUNT] - 16'h0001, 3'h0});
   assign addr_cmd = code == `CMD_EV_SECT || code == `CMD_PROG;
   assign otp_cmd = code == `CMD_OTP_READ || code == `CMD_OTP_PROG;
   // pending access or protection errors block a launch
   assign launch_try = reg_wr && reg_addr == `OFS_STATUS && reg_wdata[`BIT_DONE]
      && s.status.done && s.state == flash_seq_pkg::ST_IDLE
      && !s.status.acc_err && !s.status.prot_viol;
   assign bad_code = !addr_cmd && !otp_cmd;
   assign bad_avail = !s.cfg[cmd_slot(code)];
   assign bad_idx = s.pidx != last_idx(code);
   assign bad_align = addr_cmd && gaddr[2:0] != 3'h0;
   assign bad_addr = addr_cmd && blk < `CODE_BLK_LO;
   assign bad_cross = code == `CMD_EV_SECT && (last_addr[23]
      || last_addr[22:`BOUNDARY_BIT] != gaddr[22:`BOUNDARY_BIT]);
   assign bad_otp = otp_cmd && s.params[`IDX_ADDR] > `OTP_LAST;
   assign acc_any = bad_code | bad_avail | bad_idx | bad_align | bad_addr
      | bad_cross | bad_otp;
   assign prot_hit = code == `CMD_PROG && s.cfg[`CFG_PEN]
      && blk == s.cfg[`CFG_PBLK_LO +: 7];

   // ==========================================================
   // phrase store ports
   assign busy_otp = s.state != flash_seq_pkg::ST_IDLE
      && (s.cmd == `CMD_OTP_READ || s.cmd == `CMD_OTP_PROG);
   assign addr_a = '{otp: s.cmd == `CMD_OTP_READ || s.cmd == `CMD_OTP_PROG, idx: s.ph};
   assign addr_b = '{otp: 1'b0, idx: cpu_addr[22:3]};
   assign req = '{
      wr: s.state == flash_seq_pkg::ST_PROG_WAIT && s.timer == 8'h01,
      otp: addr_a.otp,
      idx: s.ph,
      wdata: pack_words(s.params)
   };

   flash_phrase_store #(
      .PHRASES(PHRASES),
      .OTP_PHRASES(8)
   ) u_store (
      .ref_clk(ref_clk),
      .srst(srst),
      .req(req),
      .addr_a(addr_a),
      .data_a(ph_a),
      .addr_b(addr_b),
      .data_b(ph_b)
   );

   // ==========================================================
   // next state: register port, launch, command steps
   always_comb begin
      logic [1:0] chk;
      logic [15:0] stat_word;
      next_s = s;
      chk = 2'h0;
      stat_word = 16'h0000;

      // write-one-to-clear of error flags, before any hardware set
      if (reg_wr && reg_addr == `OFS_STATUS) begin
         if (reg_wdata[`BIT_ACC]) next_s.status.acc_err = 1'b0;
         if (reg_wdata[`BIT_PROT]) next_s.status.prot_viol = 1'b0;
         if (reg_wdata[`BIT_VERR]) next_s.status.ver_err = 1'b0;
         if (reg_wdata[`BIT_VUNC]) next_s.status.ver_unc = 1'b0;
      end

      // index, parameter and config writes; parameters frozen while busy
      if (reg_wr && s.state == flash_seq_pkg::ST_IDLE) begin
         unique case (reg_addr)
            `OFS_INDEX: next_s.pidx = reg_wdata[2:0];
            `OFS_PARAM: begin
               if (s.pidx <= `IDX_LAST) next_s.params[s.pidx] = reg_wdata;
            end
            `OFS_CONFIG: next_s.cfg = reg_wdata;
            default: ;
         endcase
      end

      // read data stands only in the cycle after the strobe
      stat_word[`BIT_DONE] = s.status.done;
      stat_word[`BIT_ACC] = s.status.acc_err;
      stat_word[`BIT_PROT] = s.status.prot_viol;
      stat_word[`BIT_VERR] = s.status.ver_err;
      stat_word[`BIT_VUNC] = s.status.ver_unc;
      next_s.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `OFS_STATUS: next_s.rdata = stat_word;
            `OFS_INDEX: next_s.rdata = {13'h0000, s.pidx};
            `OFS_PARAM: next_s.rdata = s.pidx <= `IDX_LAST ? s.params[s.pidx] : 16'h0000;
            default: next_s.rdata = s.cfg;
         endcase
      end

      // cpu read of code flash, reads of the field block blanked while it is busy
      next_s.cpu_inv = cpu_rd && busy_otp && cpu_addr[22:16] == `OTP_BLK;
      next_s.cpu_rdata = 16'h0000;
      if (cpu_rd && !next_s.cpu_inv) next_s.cpu_rdata = word_of(ph_b, cpu_addr[2:1]);

      // launch: refuse with a flag or start the command
      if (launch_try) begin
         if (acc_any) begin
            next_s.status.acc_err = 1'b1;
         end else if (prot_hit) begin
            next_s.status.prot_viol = 1'b1;
         end else begin
            next_s.status.done = 1'b0;
            next_s.status.ver_err = 1'b0;
            next_s.status.ver_unc = 1'b0;
            next_s.cmd = code;
            next_s.cnt = s.params[`IDX_COUNT];
            next_s.timer = 8'(PROG_N);
            next_s.ph = otp_cmd ? {17'h00000, s.params[`IDX_ADDR][2:0]} : gaddr[22:3];
            unique case (code)
               `CMD_EV_SECT: next_s.state = flash_seq_pkg::ST_SCAN;
               `CMD_OTP_READ: next_s.state = flash_seq_pkg::ST_OTP_FETCH;
               `CMD_PROG: next_s.state = flash_seq_pkg::ST_PROG_WAIT;
               default: next_s.state = flash_seq_pkg::ST_OTP_BLANK;
            endcase
         end
      end

      // command steps
      unique case (s.state)
         flash_seq_pkg::ST_IDLE: ;
         // one phrase per cycle checked against erased
         flash_seq_pkg::ST_SCAN: begin
            chk = check(ph_a, `ERASED_PHRASE);
            if (chk[1]) next_s.status.ver_err = 1'b1;
            if (chk[0]) next_s.status.ver_unc = 1'b1;
            next_s.ph = s.ph + 20'h00001;
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
               next_s.status.done = 1'b1;
               next_s.state = flash_seq_pkg::ST_IDLE;
            end
         end
         // fetched field phrase into indices 010 to 101
         flash_seq_pkg::ST_OTP_FETCH: begin
            for (int w = 0; w < 4; w++) begin
               next_s.params[`IDX_COUNT + w] = word_of(ph_a, 2'(w));
            end
            next_s.status.done = 1'b1;
            next_s.state = flash_seq_pkg::ST_IDLE;
         end
         // a used field phrase is never programmed again
         flash_seq_pkg::ST_OTP_BLANK: begin
            if (ph_a != `ERASED_PHRASE) begin
               next_s.status.acc_err = 1'b1;
               next_s.status.done = 1'b1;
               next_s.state = flash_seq_pkg::ST_IDLE;
            end else begin
               next_s.state = flash_seq_pkg::ST_PROG_WAIT;
            end
         end
         // program pulse, phrase written on its last cycle
         flash_seq_pkg::ST_PROG_WAIT: begin
            next_s.timer = s.timer - 8'h01;
            if (s.timer == 8'h01) next_s.state = flash_seq_pkg::ST_VERIFY;
         end
         // read back against the parameter words
         default: begin
            chk = check(ph_a, pack_words(s.params));
            if (chk[1]) next_s.status.ver_err = 1'b1;
            if (chk[0]) next_s.status.ver_unc = 1'b1;
            next_s.status.done = 1'b1;
            next_s.state = flash_seq_pkg::ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= SEQ_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign cpu_rdata = s.cpu_rdata;
   assign cpu_data_invalid = s.cpu_inv;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence seq_try(logic [7:0] c);
      launch_try && code == c;
   endsequence

   sequence seq_refused;
      s.status.acc_err && s.status.done && s.state == flash_seq_pkg::ST_IDLE;
   endsequence

   sequence seq_enter_prog;
      $rose(s.state == flash_seq_pkg::ST_PROG_WAIT);
   endsequence

   a_bad_code: assert property (launch_try && bad_code |=> seq_refused)
      else $error("unknown code not refused");
   a_bad_mode: assert property (launch_try && bad_avail |=> seq_refused)
      else $error("unavailable command not refused");
   a_bad_block: assert property (launch_try && bad_addr |=> seq_refused)
      else $error("invalid address not refused");
   a_otp_range: assert property (launch_try && bad_otp |=> seq_refused)
      else $error("field phrase index out of range not refused");
   a_ev_index: assert property (seq_try(`CMD_EV_SECT) ##0 s.pidx != `IDX_COUNT
      |=> seq_refused)
      else $error("section verify with wrong index ran");
   a_read_index: assert property (seq_try(`CMD_OTP_READ) ##0 s.pidx != `IDX_ADDR
      |=> seq_refused)
      else $error("field read with wrong index ran");
   a_ev_cross: assert property (seq_try(`CMD_EV_SECT) ##0 bad_cross |=> seq_refused)
      else $error("boundary crossing not refused");
   a_misaligned: assert property (launch_try && bad_align |=> seq_refused)
      else $error("misaligned address not refused");
   a_prot_hit: assert property (seq_try(`CMD_PROG) ##0 !acc_any && prot_hit
      |=> s.status.prot_viol && s.status.done && !s.status.acc_err)
      else $error("protected program not refused");
   a_launch_start: assert property (launch_try && !acc_any && !prot_hit
      |=> !s.status.done ##1 (!s.status.done || s.state == flash_seq_pkg::ST_IDLE))
      else $error("launch did not clear complete flag");
   a_busy_flag: assert property (s.state != flash_seq_pkg::ST_IDLE |-> !s.status.done)
      else $error("complete flag set while busy");
   a_prog_time: assert property (seq_enter_prog |-> ##PROG_N
      s.state == flash_seq_pkg::ST_VERIFY)
      else $error("program pulse length wrong");
   a_scan_flag: assert property (s.state == flash_seq_pkg::ST_SCAN
      && ph_a != `ERASED_PHRASE |=> s.status.ver_err)
      else $error("erase verify mismatch not flagged");
   a_otp_load: assert property (s.state == flash_seq_pkg::ST_OTP_FETCH
      |=> s.params[`IDX_COUNT] == $past(ph_a[63:48]) && s.status.done)
      else $error("field words not loaded");
   a_otp_reprog: assert property (s.state == flash_seq_pkg::ST_OTP_BLANK
      && ph_a != `ERASED_PHRASE |=> seq_refused)
      else $error("used field phrase programmed again");
   a_cpu_blank: assert property (cpu_rd && busy_otp && cpu_addr[22:16] == `OTP_BLK
      |=> cpu_data_invalid && cpu_rdata == 16'h0000)
      else $error("read of busy field block not blanked");
endmodule // flash_code_cmd_sequencer

//--- verif/tb_top.sv
// Purpose: self-checking bench of the flash command sequencer
// Assumes: register port answers one cycle after the read strobe
// Notes: past time 0, drives every port but ref_clk by non-blocking assignment after the clock edge
`timescale 1ns/100ps
module tb_top;
   logic ref_clk;
   logic srst;
   logic [1:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic cpu_rd;
   logic [22:0] cpu_addr;
   logic [15:0] cpu_rdata;
   logic cpu_data_invalid;
   logic [15:0] pv [6];
   logic [15:0] s;
   logic [7:0] codes [4] = '{8'h03, 8'h04, 8'h06, 8'h07};
   logic [2:0] lasts [4] = '{3'h2, 3'h1, 3'h5, 3'h5};
   int fails = 0;
   int num_checks = 0;

   flash_code_cmd_sequencer #(.PHRASES(64)) flash_code_cmd_sequencer_inst (
      .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_rd(cpu_rd),
      .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_data_invalid(cpu_data_invalid)
   );

   // ==========================================================
   // clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      fails++;
      summarize();
   end

   // ==========================================================
   // compare and report tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chkb(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic tend(input string name);
      $display("test %s finished", name);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // register port and cpu read cycles
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic cpu(input logic [22:0] a);
      @(posedge ref_clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge ref_clk);
      cpu_rd <= 1'b0;
      #1;
   endtask
   task automatic setp(input logic [15:0] a, b, c, d, e, f);
      pv = '{a, b, c, d, e, f};
   endtask

   // load params, launch, optionally probe while busy, wait, check, clear flags
   task automatic go(input logic [2:0] last, input logic [2:0] lidx, input logic busy,
                     input logic [15:0] exp);
      int n;
      for (int i = 0; i <= int'(last); i++) begin
         wr(2'h1, 16'(i));
         wr(2'h2, pv[i]);
      end
      wr(2'h1, {13'h0000, lidx});
      wr(2'h0, 16'h0080);
      if (busy) begin
         rd(2'h0, s);
         chk("status while busy", 16'h0000, s);
         cpu(23'h7C0000);
         chkb("field block invalid", pv[0][15:8] == 8'h07, cpu_data_invalid);
         chk("field data", pv[0][15:8] == 8'h07 ? 16'h0000 : 16'hFFFF, cpu_rdata);
      end
      n = 0;
      do begin
         rd(2'h0, s);
         n++;
      end while (s[7] !== 1'b1 && n < 400);
      chk("final status", exp, s);
      wr(2'h0, 16'h0033);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      srst = 1'b1;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cpu_rd = 1'b0;
      cpu_addr = 23'h000000;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rd(2'h0, s);
      chk("reset status", 16'h0080, s);
      rd(2'h3, s);
      chk("reset config", 16'h000F, s);
      tend("reset");
      // commands refused when their mode bit is clear, then unknown codes refused
      wr(2'h3, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         setp({codes[i], 8'h7D}, 16'h0010, 16'h1111, 16'h2222, 16'h3333, 16'h4444);
         go(lasts[i], lasts[i], 1'b0, 16'h00A0);
      end
      wr(2'h3, 16'h000F);
      setp(16'h017D, 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h0, 3'h0, 1'b0, 16'h00A0);
      setp(16'h057D, 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h0, 3'h0, 1'b0, 16'h00A0);
      tend("modes and codes");
      // one-time field program, read back, refusals
      setp(16'h0700, 16'h0003, 16'hA5A5, 16'h5A5A, 16'h0F0F, 16'hF0F0);
      go(3'h5, 3'h5, 1'b1, 16'h0080);
      setp(16'h0400, 16'h0003, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h1, 3'h1, 1'b0, 16'h0080);
      for (int i = 2; i < 6; i++) begin
         wr(2'h1, 16'(i));
         rd(2'h2, s);
         chk("field word", i == 2 ? 16'hA5A5 : i == 3 ? 16'h5A5A :
             i == 4 ? 16'h0F0F : 16'hF0F0, s);
      end
      setp(16'h0700, 16'h0003, 16'h1234, 16'h1234, 16'h1234, 16'h1234);
      go(3'h5, 3'h5, 1'b0, 16'h00A0);
      pv[1] = 16'h0008;
      go(3'h5, 3'h5, 1'b0, 16'h00A0);
      pv[1] = 16'h0002;
      go(3'h5, 3'h4, 1'b0, 16'h00A0);
      setp(16'h0400, 16'h0008, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h1, 3'h1, 1'b0, 16'h00A0);
      pv[1] = 16'h0007;
      go(3'h1, 3'h2, 1'b0, 16'h00A0);
      tend("one-time field");
      // code flash program and its refusals
      setp(16'h067D, 16'h0010, 16'h1111, 16'h2222, 16'h3333, 16'h4444);
      go(3'h5, 3'h5, 1'b1, 16'h0080);
      cpu(23'h7D0010);
      chk("cpu word0", 16'h1111, cpu_rdata);
      cpu(23'h7D0016);
      chk("cpu word3", 16'h4444, cpu_rdata);
      chkb("cpu invalid", 1'b0, cpu_data_invalid);
      go(3'h5, 3'h4, 1'b0, 16'h00A0);
      pv[1] = 16'h0011;
      go(3'h5, 3'h5, 1'b0, 16'h00A0);
      setp(16'h0610, 16'h0018, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h5, 3'h5, 1'b0, 16'h00A0);
      wr(2'h3, 16'hFD0F);
      setp(16'h067D, 16'h0028, 16'h0, 16'h0, 16'h0, 16'h0);
      go(3'h5, 3'h5, 1'b0, 16'h0090);
      wr(2'h3, 16'h000F);
      tend("program");
      // section verify over programmed and erased phrases
      setp(16'h037D, 16'h0000, 16'h0003, 16'h0, 16'h0, 16'h0);
      go(3'h2, 3'h2, 1'b0, 16'h0083);
      setp(16'h037D, 16'h0020, 16'h0004, 16'h0, 16'h0, 16'h0);
      go(3'h2, 3'h2, 1'b0, 16'h0080);
      pv[2] = 16'h0000;
      go(3'h2, 3'h2, 1'b0, 16'h00A0);
      pv[2] = 16'h0002;
      go(3'h2, 3'h1, 1'b0, 16'h00A0);
      pv[1] = 16'h0024;
      go(3'h2, 3'h2, 1'b0, 16'h00A0);
      setp(16'h0301, 16'h0020, 16'h0002, 16'h0, 16'h0, 16'h0);
      go(3'h2, 3'h2, 1'b0, 16'h00A0);
      setp(16'h037F, 16'hFFF8, 16'h0002, 16'h0, 16'h0, 16'h0);
      go(3'h2, 3'h2, 1'b0, 16'h00A0);
      tend("section verify");
      summarize();
   end
endmodule // tb_top
